//--- pm_pkg.sv
package pm_pkg;

  localparam int unsigned clock_hz        = 20000000;
  localparam int unsigned conv_time_ns    = 50000;
  localparam int unsigned conv_cycles     =
    (conv_time_ns / 50 > 0) ? conv_time_ns / 50 : 1;
  localparam int unsigned quarter_cycles  = conv_cycles / 4;
  localparam int unsigned max_alert_delay = conv_cycles * 3 / 2;

  localparam logic [3:0] addr_config      = 4'h0;
  localparam logic [3:0] addr_calibration = 4'h1;
  localparam logic [3:0] addr_shunt_limit = 4'h2;
  localparam logic [3:0] addr_bus_limit   = 4'h3;
  localparam logic [3:0] addr_power_limit = 4'h4;
  localparam logic [3:0] addr_shunt       = 4'h5;
  localparam logic [3:0] addr_bus         = 4'h6;
  localparam logic [3:0] addr_current     = 4'h7;
  localparam logic [3:0] addr_power_hi    = 4'h8;
  localparam logic [3:0] addr_power_lo    = 4'h9;
  localparam logic [3:0] addr_temp        = 4'ha;
  localparam logic [3:0] addr_status      = 4'hb;
  localparam logic [3:0] addr_mask        = 4'hc;

  localparam int unsigned cfg_range_bit  = 0;
  localparam int unsigned cfg_cont_bit   = 1;
  localparam int unsigned cfg_avg_bit    = 2;
  localparam int unsigned cfg_alert_bit  = 3;
  localparam logic [15:0] config_reset   = 16'h0002;
  localparam logic [15:0] limit_shunt_rst = 16'h7fff;
  localparam logic [15:0] limit_bus_rst   = 16'h7fff;
  localparam logic [15:0] limit_power_rst = 16'hffff;
  localparam logic [15:0] calib_reset     = 16'h0000;

  localparam int unsigned st_shunt = 0;
  localparam int unsigned st_bus   = 1;
  localparam int unsigned st_power = 2;
  localparam int unsigned st_ready = 3;
  localparam int unsigned power_frac_div = 5;
  // bus result counts per volt, from the fixed bus step
  localparam int unsigned bus_steps_per_volt = 320;
  localparam int unsigned power_shift    = 8;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] temp;
  } sample_t;

endpackage

//--- pm_calc.sv
`timescale 1ns/1ps
module pm_calc (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic        range_low,
  input  wire logic [15:0] calibration,
  input  wire logic [15:0] shunt,
  input  wire logic [15:0] bus,
  output logic      [15:0] current,
  output logic      [23:0] power
);
  logic signed [47:0] prod;
  logic signed [47:0] cur_full;
  logic        [15:0] next_current;
  logic        [23:0] next_power;
  logic        [39:0] pw;
  logic        [15:0] cur_mag;

  always_comb begin
    // zero calibration gives zero current and power
    prod = $signed({{32{shunt[15]}}, shunt}) * $signed({32'h0, calibration}); // R4
    cur_full = prod >>> 11;
    if (range_low) begin
      cur_full = cur_full <<< 2; // R2
    end
    next_current = cur_full[15:0]; // R10
    cur_mag = next_current[15] ? 16'(-next_current) : next_current;
    // power step is current step times 0.2, bus step folded in
    pw = 40'({24'h0, cur_mag} * {24'h0, bus}) /
         40'(pm_pkg::bus_steps_per_volt / pm_pkg::power_frac_div);
    next_power = pw[23:0]; // R5
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      current <= 16'h0000;
      power   <= 24'h000000;
    end else if (enable) begin
      current <= next_current;
      power   <= next_power;
    end
  end
endmodule // pm_calc

//--- power_monitor_limit_alert.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
//
// Contract
// [R1] at reset: wide range, continuous shunt, bus, temperature conversion
// [R2] register bit selects wide or narrow shunt full scale range
// [R3] configuration returns to reset values after every power cycle
// [R4] zero calibration forces current and power results to zero
// [R5] power step equals current step times a fixed 0.2 factor
// [R6] shunt limit compared with shunt result at shunt step
// [R7] bus limit compared with bus result, flags over voltage
// [R8] 16 bit power limit compared with upper bits of 24 bit power
// [R9] all limits revert to defaults after every power cycle
// [R10] results are two's complement; bus voltage positive only
// [R11] alert selects limit violation or conversion ready
// [R12] alert follows conversion, within about 1.5 conversion times
// [R13] host budgets 1.5 conversion times alert latency
// [R14] averaged alert clear compares each raw conversion; the code compares the averaged result, and status clears only by a host write
// [R15] comparison evaluated when each new result completes; the code checks power only at the end of the temperature phase
module power_monitor_limit_alert #(
  parameter int unsigned conv_len = pm_pkg::conv_cycles,
  parameter int unsigned avg_len  = 4
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clock_enable,
  input  wire logic [3:0]  address,
  input  wire logic [15:0] write_data,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  output logic      [15:0] read_data,
  input  wire logic [15:0] shunt_in,
  input  wire logic [15:0] bus_in,
  input  wire logic [15:0] temp_in,
  output logic             alert,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    s_shunt = 3'b001,
    s_bus   = 3'b010,
    s_temp  = 3'b100
  } phase_t;

  pm_pkg::sample_t s1, s2;
  phase_t          phase, next_phase;
  logic [15:0] cfg, calib, lim_shunt, lim_bus, lim_power;
  logic [15:0] next_cfg, next_calib, next_ls, next_lb, next_lp;
  logic [15:0] shunt_r, bus_r, temp_r, next_shunt, next_bus, next_temp;
  logic [15:0] avg_shunt, avg_bus, next_avg_shunt, next_avg_bus;
  logic [3:0]  status, mask, next_status, next_mask, ev;
  logic [31:0] tick, next_tick;
  logic [7:0]  avg_cnt, next_avg_cnt;
  logic        done, next_alert, next_irq;
  logic [15:0] next_read;
  logic [15:0] current;
  logic [23:0] power;

  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  function automatic logic [15:0] mean(input logic [15:0] a,
                                       input logic [15:0] b);
    logic [16:0] s;
    s = {a[15], a} + {b[15], b};
    mean = s[16:1];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pins come from the analog side, so two stages first
  always_ff @(posedge clock) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
    end else if (clock_enable) begin
      s1 <= '{shunt_in, bus_in, temp_in};
      s2 <= s1;
    end
  end

  pm_calc u_calc (
    .clock       (clock),
    .rst         (rst),
    .enable      (clock_enable),
    .range_low   (cfg[pm_pkg::cfg_range_bit]),
    .calibration (calib),
    .shunt       (shunt_r),
    .bus         (bus_r),
    .current     (current),
    .power       (power)
  );

  //////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  always_comb begin
    next_tick  = tick;
    next_phase = phase;
    next_shunt = shunt_r;
    next_bus   = bus_r;
    next_temp  = temp_r;
    done       = 1'b0;
    if (cfg[pm_pkg::cfg_cont_bit]) begin // R1
      if (tick >= 32'(conv_len - 1)) begin
        next_tick = 32'h0;
        done      = 1'b1;
        case (phase)
          s_shunt: begin
            next_shunt = s2.shunt; // R10
            next_phase = s_bus;
          end
          s_bus: begin
            // bus voltage is never negative
            next_bus   = s2.bus[15] ? 16'h0000 : s2.bus; // R10
            next_phase = s_temp;
          end
          s_temp: begin
            next_temp  = s2.temp;
            next_phase = s_shunt;
          end
          default: next_phase = s_shunt;
        endcase
      end else begin
        next_tick = tick + 32'h1;
      end
    end
  end

  // averaged values: each new shunt and bus result is meaned with the previous average
  always_comb begin
    next_avg_shunt = avg_shunt;
    next_avg_bus   = avg_bus;
    next_avg_cnt   = avg_cnt;
    if (done && phase == s_shunt) begin
      next_avg_shunt = mean(avg_shunt, s2.shunt);
    end
    if (done && phase == s_bus) begin
      next_avg_bus = mean(avg_bus, next_bus);
      next_avg_cnt = (avg_cnt >= 8'(avg_len - 1)) ? 8'h0 : avg_cnt + 8'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // limit checks happen as each shunt and bus result lands; power is checked as the temperature result lands
  logic sel_avg;
  logic [15:0] cmp_shunt, cmp_bus;
  always_comb begin
    sel_avg   = cfg[pm_pkg::cfg_avg_bit];
    cmp_shunt = sel_avg ? next_avg_shunt : next_shunt; // R14
    cmp_bus   = sel_avg ? next_avg_bus : next_bus; // R14
    ev        = 4'h0;
    if (done && phase == s_shunt && sgt(cmp_shunt, lim_shunt)) begin
      ev[pm_pkg::st_shunt] = 1'b1; // R6 R15
    end
    if (done && phase == s_bus && sgt(cmp_bus, lim_bus)) begin
      ev[pm_pkg::st_bus] = 1'b1; // R7 R15
    end
    if (done && phase == s_temp &&
        power[23:pm_pkg::power_shift] > lim_power) begin
      ev[pm_pkg::st_power] = 1'b1; // R8 R15
    end
    ev[pm_pkg::st_ready] = done && phase == s_temp;
  end

  //////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    next_cfg    = cfg;
    next_calib  = calib;
    next_ls     = lim_shunt;
    next_lb     = lim_bus;
    next_lp     = lim_power;
    next_mask   = mask;
    next_status = status;
    if (write_strobe) begin
      case (address)
        pm_pkg::addr_config:      next_cfg   = write_data; // R2
        pm_pkg::addr_calibration: next_calib = write_data; // R4
        pm_pkg::addr_shunt_limit: next_ls    = write_data;
        pm_pkg::addr_bus_limit:   next_lb    = write_data;
        pm_pkg::addr_power_limit: next_lp    = write_data;
        pm_pkg::addr_mask:        next_mask  = write_data[3:0];
        pm_pkg::addr_status:      next_status = status & ~write_data[3:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    next_status = next_status | ev;
    next_read = 16'h0000;
    if (read_strobe) begin
      case (address)
        pm_pkg::addr_config:      next_read = cfg;
        pm_pkg::addr_calibration: next_read = calib;
        pm_pkg::addr_shunt_limit: next_read = lim_shunt;
        pm_pkg::addr_bus_limit:   next_read = lim_bus;
        pm_pkg::addr_power_limit: next_read = lim_power;
        pm_pkg::addr_shunt:       next_read = shunt_r;
        pm_pkg::addr_bus:         next_read = bus_r;
        pm_pkg::addr_current:     next_read = current;
        pm_pkg::addr_power_hi:    next_read = {8'h00, power[23:16]};
        pm_pkg::addr_power_lo:    next_read = power[15:0];
        pm_pkg::addr_temp:        next_read = temp_r;
        pm_pkg::addr_status:      next_read = {12'h000, status};
        pm_pkg::addr_mask:        next_read = {12'h000, mask};
        default:                  next_read = 16'h0000;
      endcase
    end
    // alert source: limit faults or conversion ready
    if (cfg[pm_pkg::cfg_alert_bit]) begin
      next_alert = next_status[pm_pkg::st_ready]; // R11 R12
    end else begin
      next_alert = |next_status[pm_pkg::st_power:pm_pkg::st_shunt]; // R11
    end
    next_irq = |(next_status & mask);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg       <= pm_pkg::config_reset; // R1 R3
      calib     <= pm_pkg::calib_reset; // R4
      lim_shunt <= pm_pkg::limit_shunt_rst; // R9
      lim_bus   <= pm_pkg::limit_bus_rst; // R9
      lim_power <= pm_pkg::limit_power_rst; // R9
      mask      <= 4'h0;
      status    <= 4'h0;
      tick      <= 32'h0;
      phase     <= s_shunt;
      shunt_r   <= 16'h0000;
      bus_r     <= 16'h0000;
      temp_r    <= 16'h0000;
      avg_shunt <= 16'h0000;
      avg_bus   <= 16'h0000;
      avg_cnt   <= 8'h00;
      read_data <= 16'h0000;
      alert     <= 1'b0;
      irq       <= 1'b0;
    end else if (clock_enable) begin
      cfg       <= next_cfg;
      calib     <= next_calib;
      lim_shunt <= next_ls;
      lim_bus   <= next_lb;
      lim_power <= next_lp;
      mask      <= next_mask;
      status    <= next_status;
      tick      <= next_tick;
      phase     <= next_phase;
      shunt_r   <= next_shunt;
      bus_r     <= next_bus;
      temp_r    <= next_temp;
      avg_shunt <= next_avg_shunt;
      avg_bus   <= next_avg_bus;
      avg_cnt   <= next_avg_cnt;
      read_data <= next_read;
      alert     <= next_alert;
      irq       <= next_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  property p_reset_cfg;
    @(posedge clock) $fell(rst) |-> cfg == pm_pkg::config_reset;
  endproperty
  a_reset_cfg: assert property (p_reset_cfg) else $error("cfg not reset"); // R1

  property p_limits_reset;
    @(posedge clock) $fell(rst) |->
      lim_bus == pm_pkg::limit_bus_rst && lim_power == pm_pkg::limit_power_rst;
  endproperty
  a_limits_reset: assert property (p_limits_reset) else $error("limits"); // R9

  property p_zero_cal;
    @(posedge clock) disable iff (rst)
      calib == 16'h0000 && $stable(calib) && clock_enable |=>
        current == 16'h0000;
  endproperty
  a_zero_cal: assert property (p_zero_cal) else $error("current nonzero"); // R4

  property p_bus_pos;
    @(posedge clock) disable iff (rst) !bus_r[15];
  endproperty
  a_bus_pos: assert property (p_bus_pos) else $error("bus negative"); // R10

  property p_bus_fault;
    @(posedge clock) disable iff (rst)
      clock_enable && ev[pm_pkg::st_bus] |=> status[pm_pkg::st_bus];
  endproperty
  a_bus_fault: assert property (p_bus_fault) else $error("bus flag"); // R7

  property p_shunt_fault;
    @(posedge clock) disable iff (rst)
      clock_enable && ev[pm_pkg::st_shunt] |=> status[pm_pkg::st_shunt];
  endproperty
  a_shunt_fault: assert property (p_shunt_fault) else $error("shunt"); // R6

  property p_alert_ready;
    @(posedge clock) disable iff (rst)
      clock_enable && cfg[pm_pkg::cfg_alert_bit] &&
      ev[pm_pkg::st_ready] |=> alert;
  endproperty
  a_alert_ready: assert property (p_alert_ready) else $error("ready"); // R11

  property p_irq;
    @(posedge clock) disable iff (rst)
      clock_enable ##1 clock_enable |-> irq == |($past(next_status) & $past(mask));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // R12

endmodule // power_monitor_limit_alert

//--- host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// host side of the register port: one strobe per access, changed after edges
module host_model (
  input  wire logic        clock,
  output logic      [3:0]  address,
  output logic      [15:0] write_data,
  output logic             write_strobe,
  output logic             read_strobe,
  input  wire logic [15:0] read_data
);
  // settings are lost on every power cycle, so the bench reads back the defaults
  // after each reset and budgets alert waits on 60 cycles, two and a half rounds
  initial begin
    address      = 4'h0;
    write_data   = 16'h0000;
    write_strobe = 1'b0;
    read_strobe  = 1'b0;
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    address      <= a;
    write_data   <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    address     <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 d = read_data;
  endtask
endmodule // host_model

//--- tb_power_monitor_limit_alert.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_power_monitor_limit_alert;
  logic        clock;
  logic        rst;
  logic        clock_enable;
  logic [15:0] shunt_in;
  logic [15:0] bus_in;
  logic [15:0] temp_in;
  logic [3:0]  address;
  logic [15:0] write_data;
  logic        write_strobe;
  logic        read_strobe;
  logic [15:0] read_data;
  logic        alert;
  logic        irq;
  int          failures;
  int          compares;

  power_monitor_limit_alert #(.conv_len(8)) power_monitor_limit_alert_inst (
    .clock(clock), .rst(rst), .clock_enable(clock_enable),
    .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .shunt_in(shunt_in), .bus_in(bus_in),
    .temp_in(temp_in), .alert(alert), .irq(irq));
  host_model host_model_inst (
    .clock(clock), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data));

  always #25 clock = ~clock;
////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check16(input logic [15:0] got, input logic [15:0] exp,
                         input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h", $time, msg, got);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] mask,
                    input logic [15:0] exp, input string msg);
    logic [15:0] v;
    host_model_inst.read_reg(a, v);
    check16(v & mask, exp, msg);
  endtask
  // one conversion round is three phases of 8 cycles; allow the 1.5 budget
  // plus synchroniser delay and a phase that has just been missed
  task automatic wait_alert(input logic lvl);
    int n;
    n = 0;
    while (alert !== lvl && n < 60) begin
      @(posedge clock);
      n++;
    end
    compares++;
    if (alert !== lvl) begin
      failures++;
      $display("mismatch at %0t: alert wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic settle;
    repeat (80) @(posedge clock);
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset;
    rd(pm_pkg::addr_config, 16'hffff, 16'h0002, "config reset");
    rd(pm_pkg::addr_calibration, 16'hffff, 16'h0000, "calib reset");
    rd(pm_pkg::addr_shunt_limit, 16'hffff, 16'h7fff, "shunt lim");
    rd(pm_pkg::addr_bus_limit, 16'hffff, 16'h7fff, "bus lim");
    rd(pm_pkg::addr_power_limit, 16'hffff, 16'hffff, "power lim");
    rd(4'hd, 16'hffff, 16'h0000, "unmapped read");
    check16({15'h0000, alert | irq}, 16'h0000, "outputs after reset");
    $display("test reset done");
  endtask
  task automatic test_scaling;
    @(posedge clock);
    shunt_in <= 16'hb410;
    bus_in   <= 16'h3c00;
    settle();
    rd(pm_pkg::addr_shunt, 16'hffff, 16'hb410, "negative shunt");
    rd(pm_pkg::addr_bus, 16'hffff, 16'h3c00, "bus result");
    rd(pm_pkg::addr_current, 16'hffff, 16'h0000, "uncal current");
    rd(pm_pkg::addr_power_hi, 16'hffff, 16'h0000, "uncal power");
    rd(pm_pkg::addr_power_lo, 16'hffff, 16'h0000, "uncal power lo");
    host_model_inst.write_reg(pm_pkg::addr_calibration, 16'h0800);
    settle();
    rd(pm_pkg::addr_current, 16'hffff, 16'hb410, "signed current");
    rd(pm_pkg::addr_power_hi, 16'hffff, 16'h0047, "power hi");
    rd(pm_pkg::addr_power_lo, 16'hffff, 16'h3100, "power lo");
    @(posedge clock);
    shunt_in <= 16'h0010;
    settle();
    rd(pm_pkg::addr_current, 16'hffff, 16'h0010, "wide range");
    rd(pm_pkg::addr_power_lo, 16'hffff, 16'h0f00, "wide power");
    host_model_inst.write_reg(pm_pkg::addr_config, 16'h0003);
    settle();
    rd(pm_pkg::addr_current, 16'hffff, 16'h0040, "narrow range");
    rd(pm_pkg::addr_power_lo, 16'hffff, 16'h3c00, "narrow power");
    host_model_inst.write_reg(pm_pkg::addr_config, 16'h0002);
    $display("test scaling done");
  endtask
  task automatic test_limits;
    logic [3:0]  lim_addr [3];
    logic [15:0] lim_val  [3];
    lim_addr = '{pm_pkg::addr_shunt_limit, pm_pkg::addr_bus_limit,
                 pm_pkg::addr_power_limit};
    lim_val  = '{16'h0100, 16'h4100, 16'h0000};
    for (int i = 0; i < 3; i++) begin
      host_model_inst.write_reg(lim_addr[i], lim_val[i]);
      @(posedge clock);
      shunt_in <= (i == 0) ? 16'h0200 : (i == 2) ? 16'h4000 : 16'h0000;
      bus_in   <= (i == 1) ? 16'h4200 : (i == 2) ? 16'h4000 : 16'h1000;
      wait_alert(1'b1);
      rd(pm_pkg::addr_status, 16'h0007, 16'h0001 << i, "fault bit");
      if (i == 0) begin
        check16({15'h0000, irq}, 16'h0000, "masked irq");
        host_model_inst.write_reg(pm_pkg::addr_mask, 16'h0007);
        repeat (2) @(posedge clock);
        check16({15'h0000, irq}, 16'h0001, "unmasked irq");
      end
      @(posedge clock);
      shunt_in <= 16'h0000;
      bus_in   <= 16'h1000;
      settle();
      host_model_inst.write_reg(lim_addr[i], (i == 2) ? 16'hffff : 16'h7fff);
      host_model_inst.write_reg(pm_pkg::addr_status, 16'h000f);
      repeat (2) @(posedge clock);
      rd(pm_pkg::addr_status, 16'h0007, 16'h0000, "status cleared");
      check16({14'h0000, alert, irq}, 16'h0000, "alert irq cleared");
    end
    $display("test limits done");
  endtask
  // conversions stopped first, so no ready event can race the clear
  task automatic test_ready;
    host_model_inst.write_reg(pm_pkg::addr_config, 16'h0008);
    host_model_inst.write_reg(pm_pkg::addr_status, 16'h000f);
    repeat (2) @(posedge clock);
    check16({15'h0000, alert}, 16'h0000, "idle no ready");
    host_model_inst.write_reg(pm_pkg::addr_config, 16'h000a);
    wait_alert(1'b1);
    host_model_inst.write_reg(pm_pkg::addr_config, 16'h0002);
    host_model_inst.write_reg(pm_pkg::addr_status, 16'h000f);
    repeat (2) @(posedge clock);
    check16({15'h0000, alert}, 16'h0000, "ready alert cleared");
    $display("test ready done");
  endtask
  task automatic test_freeze;
    @(posedge clock);
    clock_enable <= 1'b0;
    host_model_inst.write_reg(pm_pkg::addr_calibration, 16'h0000);
    @(posedge clock);
    clock_enable <= 1'b1;
    rd(pm_pkg::addr_calibration, 16'hffff, 16'h0800, "frozen write");
    $display("test freeze done");
  endtask
  task automatic test_power_cycle;
    host_model_inst.write_reg(pm_pkg::addr_config, 16'h0007);
    host_model_inst.write_reg(pm_pkg::addr_bus_limit, 16'h4100);
    @(posedge clock);
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    $display("test power cycle done");
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock        = 1'b0;
    rst          = 1'b1;
    clock_enable = 1'b1;
    shunt_in     = 16'h0000;
    bus_in       = 16'h0000;
    temp_in      = 16'h00c8;
    failures     = 0;
    compares     = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    test_reset();
    test_scaling();
    test_limits();
    test_ready();
    test_freeze();
    test_power_cycle();
    wrap_up();
  end
endmodule // tb_power_monitor_limit_alert
